// file: rtl/psr_pkg.sv
// constants and carrier types for the peripheral state and mac reset registers
package psr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int unsigned WB_AW = 32;
    localparam int unsigned WB_DW = 32;
    localparam int unsigned WB_SW = 4;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [31:0] STATE_REPORT0_OFS = 32'h02ac0014;
    localparam logic [31:0] STATE_REPORT1_OFS = 32'h02ac0018;
    localparam logic [31:0] MAC_CONFIG_OFS    = 32'h02ac0020;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [31:0] STATE_REPORT_RST = 32'h00000000;
    localparam logic [31:0] MAC_CONFIG_RST   = 32'h00000000;
    localparam logic        RMII_RESET_RST   = 1'h0;

    ////////////////////////////////////////////////////////////////////////////
    // mac configuration fields
    localparam int unsigned RMII_RESET_BIT  = 18;
    localparam int unsigned RMII_RESET_LANE = 2;

    ////////////////////////////////////////////////////////////////////////////
    // peripheral state codes
    localparam logic [2:0] CODE_DISABLED    = 3'h0;
    localparam logic [2:0] CODE_ENABLED     = 3'h1;
    localparam logic [2:0] CODE_POWERDOWN   = 3'h3;
    localparam logic [2:0] CODE_IN_PROGRESS = 3'h5;
    localparam int unsigned CODE_W          = 3;

    ////////////////////////////////////////////////////////////////////////////
    // peripheral indices, field positions and owning register
    localparam int unsigned NUM_PERIPH         = 9;
    localparam int unsigned IDX_HOST_PORT      = 0;
    localparam int unsigned IDX_SERIAL_PORT1   = 1;
    localparam int unsigned IDX_SERIAL_PORT0   = 2;
    localparam int unsigned IDX_TWO_WIRE       = 3;
    localparam int unsigned IDX_GENERAL_IO     = 4;
    localparam int unsigned IDX_SECOND_COUNTER = 5;
    localparam int unsigned IDX_FIRST_COUNTER  = 6;
    localparam int unsigned IDX_ETHERNET       = 7;
    localparam int unsigned IDX_PCI_BUS        = 8;
    localparam int unsigned FIELD_LSB [NUM_PERIPH] =
        '{27, 24, 21, 18, 15, 12, 9, 6, 0};
    localparam int unsigned FIELD_REG [NUM_PERIPH] =
        '{0, 0, 0, 0, 0, 0, 0, 0, 1};

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned ENABLE_DONE_CYCLES = 16;

    ////////////////////////////////////////////////////////////////////////////
    // carrier types
    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [WB_SW-1:0] sel;
        logic [WB_AW-1:0] adr;
        logic [WB_DW-1:0] dat;
    } psr_wb_req_type;

    typedef struct packed {
        logic             ack;
        logic [WB_DW-1:0] dat;
    } psr_wb_rsp_type;

    typedef enum logic [1:0] {
        PSR_DIS  = 2'b00,
        PSR_PROG = 2'b01,
        PSR_ENA  = 2'b11,
        PSR_PDN  = 2'b10
    } psr_fsm_type;

endpackage

// file: rtl/psr_state_tracker.sv
// per-peripheral power and enable state tracker producing a 3-bit code
`timescale 1ns/1ps
module psr_state_tracker #(
    parameter int unsigned DONE_CYCLES = psr_pkg::ENABLE_DONE_CYCLES
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // peripheral controls
    input  wire logic       enable_i,
    input  wire logic       powerdown_i,
    // state report
    output logic [2:0]      state_code_o
);

    localparam int unsigned CW = $clog2(DONE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(DONE_CYCLES - 1);

    psr_pkg::psr_fsm_type state_r;
    psr_pkg::psr_fsm_type state_nxt;
    logic [CW-1:0]        cnt_r;
    logic [2:0]           code_r;

    function automatic logic [2:0] code_of(input psr_pkg::psr_fsm_type s);
        case (s)
            psr_pkg::PSR_PROG: code_of = psr_pkg::CODE_IN_PROGRESS;
            psr_pkg::PSR_ENA:  code_of = psr_pkg::CODE_ENABLED;
            psr_pkg::PSR_PDN:  code_of = psr_pkg::CODE_POWERDOWN;
            default:           code_of = psr_pkg::CODE_DISABLED;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state; dropping the enable wins from any state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            psr_pkg::PSR_DIS: begin
                if (enable_i)
                    state_nxt = psr_pkg::PSR_PROG;
            end
            psr_pkg::PSR_PROG: begin
                if (!enable_i)
                    state_nxt = psr_pkg::PSR_DIS;
                else if (cnt_r == LAST)
                    state_nxt = psr_pkg::PSR_ENA;
            end
            psr_pkg::PSR_ENA: begin
                if (!enable_i)
                    state_nxt = psr_pkg::PSR_DIS;
                else if (powerdown_i)
                    state_nxt = psr_pkg::PSR_PDN;
            end
            psr_pkg::PSR_PDN: begin
                if (!enable_i)
                    state_nxt = psr_pkg::PSR_DIS;
                else if (!powerdown_i)
                    state_nxt = psr_pkg::PSR_ENA;
            end
            default: state_nxt = psr_pkg::PSR_DIS;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            state_r <= psr_pkg::PSR_DIS;
        else
            state_r <= state_nxt;
    end

    // in-progress lasts exactly DONE_CYCLES cycles
    always_ff @(posedge clk_i) begin
        if (rst_i)
            cnt_r <= '0;
        else if (state_r == psr_pkg::PSR_PROG)
            cnt_r <= cnt_r + CW'(1);
        else
            cnt_r <= '0;
    end

    // code follows the state register, not a cycle behind it
    always_ff @(posedge clk_i) begin
        if (rst_i)
            code_r <= psr_pkg::CODE_DISABLED;
        else
            code_r <= code_of(state_nxt);
    end

    assign state_code_o = code_r;

endmodule

// file: rtl/psr_regs.sv
// wishbone register bank: peripheral state reports and mac rmii reset
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - host port state code sits in bits 29:27 of state report 0.
// - second serial port state code sits in bits 26:24 of report 0.
// - first serial port state code sits in bits 23:21 of report 0.
// - two-wire controller state code sits in bits 20:18 of report 0.
// - general io state code sits in bits 17:15 of report 0.
// - second counter state code sits in bits 14:12 of report 0.
// - first counter state code sits in bits 11:9 of report 0.
// - ethernet mac state code sits in bits 8:6 of report 0.
// - pci bus state code sits in bits 2:0 of state report 1.
// - both reports are read only, read zero after reset, ignore writes.
// - bit 18 of the mac config register holds the rmii logic in reset.
// - external memory and ddr2 controller have no report field.
module psr_regs #(
    parameter int unsigned DONE_CYCLES = psr_pkg::ENABLE_DONE_CYCLES
) (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // wishbone slave
    input  wire psr_pkg::psr_wb_req_type    wb_req_i,
    output psr_pkg::psr_wb_rsp_type         wb_rsp_o,
    // peripheral controls, same clock domain
    input  wire logic [8:0]                 periph_enable_i,
    input  wire logic [8:0]                 periph_powerdown_i,
    // mac side
    output logic                            rmii_reset_o
);

    logic [2:0]  codes [psr_pkg::NUM_PERIPH];
    logic [31:0] report0;
    logic [31:0] report1;
    logic [31:0] mac_word;
    logic        req;
    logic        ack_r;
    logic [31:0] dat_r;
    logic        rmii_r;

    function automatic logic hit(input logic [31:0] adr,
                                 input logic [31:0] ofs);
        hit = (adr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // one tracker per reported peripheral
    for (genvar g = 0; g < psr_pkg::NUM_PERIPH; g++) begin : g_trk
        psr_state_tracker #(
            .DONE_CYCLES (DONE_CYCLES)
        ) u_trk (
            .clk_i        (clk_i),
            .rst_i        (rst_i),
            .enable_i     (periph_enable_i[g]),
            .powerdown_i  (periph_powerdown_i[g]),
            .state_code_o (codes[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // report words; reserved bits stay zero
    always_comb begin
        report0 = psr_pkg::STATE_REPORT_RST;
        report1 = psr_pkg::STATE_REPORT_RST;
        for (int i = 0; i < psr_pkg::NUM_PERIPH; i++) begin
            if (psr_pkg::FIELD_REG[i] == 0)
                report0[psr_pkg::FIELD_LSB[i] +: 3] = codes[i];
            else
                report1[psr_pkg::FIELD_LSB[i] +: 3] = codes[i];
        end
    end
    // field map
    // field map

    // reserved bits read back their defaults whatever was written
    always_comb begin
        mac_word = psr_pkg::MAC_CONFIG_RST;
        mac_word[psr_pkg::RMII_RESET_BIT] = rmii_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, ack drops the cycle after it rose
    assign req = wb_req_i.cyc & wb_req_i.stb;

    always_ff @(posedge clk_i) begin
        if (rst_i)
            ack_r <= 1'h0;
        else
            ack_r <= req & ~ack_r;
    end

    // unmapped addresses, and external memory or ddr2, answer zero
    always_ff @(posedge clk_i) begin
        if (rst_i)
            dat_r <= 32'h00000000;
        else if (req & ~ack_r & ~wb_req_i.we) begin
            if (hit(wb_req_i.adr, psr_pkg::STATE_REPORT0_OFS))
                dat_r <= report0;
            else if (hit(wb_req_i.adr, psr_pkg::STATE_REPORT1_OFS))
                dat_r <= report1;
            else if (hit(wb_req_i.adr, psr_pkg::MAC_CONFIG_OFS))
                dat_r <= mac_word;
            else
                dat_r <= 32'h00000000;
        end
    end

    // only the mac config takes writes; reports ignore them
    always_ff @(posedge clk_i) begin
        if (rst_i)
            rmii_r <= psr_pkg::RMII_RESET_RST;
        else if (req & ~ack_r & wb_req_i.we
                 & wb_req_i.sel[psr_pkg::RMII_RESET_LANE]
                 & hit(wb_req_i.adr, psr_pkg::MAC_CONFIG_OFS))
            rmii_r <= wb_req_i.dat[psr_pkg::RMII_RESET_BIT];
    end
    // writes to either report leave it untouched

    assign wb_rsp_o.ack = ack_r;
    assign wb_rsp_o.dat = dat_r;
    assign rmii_reset_o = rmii_r;

endmodule

// file: tb/psr_regs_properties.sv
// checker for the state report and mac reset register bank
`timescale 1ns/1ps
module psr_regs_properties #(
    parameter int unsigned DONE_CYCLES = 16
) (
    // watched ports
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire psr_pkg::psr_wb_req_type wb_req_i,
    input wire psr_pkg::psr_wb_rsp_type wb_rsp_o,
    input wire logic [8:0]              periph_enable_i,
    input wire logic [8:0]              periph_powerdown_i,
    input wire logic                    rmii_reset_o
);
    logic tk;
    logic rd;
    logic wm;
    logic [31:0] a;
    assign a  = wb_req_i.adr;
    assign tk = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
    assign rd = tk && !wb_req_i.we;
    assign wm = tk && wb_req_i.we && wb_req_i.sel[2]
                && a == psr_pkg::MAC_CONFIG_OFS;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    a_ack_pulse: assert property (
        tk |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
        else $error("ack is not a single pulse");
    a_rmii_set: assert property (
        wm && wb_req_i.dat[18] |=> rmii_reset_o)
        else $error("rmii reset not asserted");
    a_rmii_clear: assert property (
        wm && !wb_req_i.dat[18] |=> !rmii_reset_o)
        else $error("rmii reset not released");
    a_rmii_hold: assert property (
        !wm |=> $stable(rmii_reset_o))
        else $error("rmii reset moved without a write");
    a_report0_rsvd: assert property (rd && a == psr_pkg::STATE_REPORT0_OFS
        |=> wb_rsp_o.dat[31:30] == 2'h0 && wb_rsp_o.dat[5:0] == 6'h0)
        else $error("report 0 reserved bits set");
    a_report1_rsvd: assert property (rd && a == psr_pkg::STATE_REPORT1_OFS
        |=> wb_rsp_o.dat[31:3] == 29'h0)
        else $error("report 1 reserved bits set");
    a_idle_zero: assert property (rd && a == psr_pkg::STATE_REPORT0_OFS
        && periph_enable_i == 9'h0 && $past(periph_enable_i) == 9'h0
        && $past(periph_enable_i, 2) == 9'h0 |=> wb_rsp_o.dat == 32'h0)
        else $error("report 0 not zero while all disabled");
    a_mac_rsvd: assert property (rd && a == psr_pkg::MAC_CONFIG_OFS
        |=> (wb_rsp_o.dat & 32'hfffbffff) == 32'h0)
        else $error("mac config reserved bits set");
    c_mac_write: cover property (wm);
    c_pci_read: cover property (rd && a == psr_pkg::STATE_REPORT1_OFS);
    c_powerdown: cover property ((periph_powerdown_i & periph_enable_i) != 0);
endmodule
bind psr_regs psr_regs_properties #(.DONE_CYCLES(DONE_CYCLES)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .periph_enable_i(periph_enable_i),
    .periph_powerdown_i(periph_powerdown_i), .rmii_reset_o(rmii_reset_o));

// file: tb/testbench.sv
// self-checking bench for the state report and mac reset registers
`timescale 1ns/1ps
module testbench;
    // short in-progress time keeps the run brief
    localparam int unsigned DONE  = 8;
    localparam int unsigned LIMIT = 3000;
    localparam logic [31:0] R0 = psr_pkg::STATE_REPORT0_OFS;
    localparam logic [31:0] R1 = psr_pkg::STATE_REPORT1_OFS;
    localparam logic [31:0] MC = psr_pkg::MAC_CONFIG_OFS;
    logic                    clk;
    logic                    rst;
    psr_pkg::psr_wb_req_type req;
    psr_pkg::psr_wb_rsp_type rsp;
    logic [8:0]              en;
    logic [8:0]              pd;
    logic                    rmii;
    logic [31:0]             q;
    int                      fails;
    int                      checks;
    int                      cycles;
    int unsigned             lsb [9] = '{27, 24, 21, 18, 15, 12, 9, 6, 0};

    always #2 clk = ~clk;

    psr_regs #(.DONE_CYCLES(DONE)) i_dut (.clk_i(clk), .rst_i(rst),
        .wb_req_i(req), .wb_rsp_o(rsp), .periph_enable_i(en),
        .periph_powerdown_i(pd), .rmii_reset_o(rmii));

    ////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one classic cycle; waits on ack, the timeout ends a hang
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
             input logic [3:0] s, output logic [31:0] r);
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
        do @(posedge clk); while (rsp.ack !== 1'b1);
        r = rsp.dat;
        req <= '0;
    endtask

    ////////////////////////////////////////////////////////////////
    task t_reset;
        bus(1'b0, R0, 32'h0, 4'hf, q); check(q, 32'h0);
        bus(1'b0, R1, 32'h0, 4'hf, q); check(q, 32'h0);
        bus(1'b0, MC, 32'h0, 4'hf, q); check(q, 32'h0);
        check(32'(rmii), 32'h0);
    endtask

    // reports ignore writes; an unmapped place reads zero
    task t_readonly;
        logic [31:0] ads [3] = '{R0, R1, 32'h02ac001c};
        foreach (ads[k]) begin
            bus(1'b1, ads[k], 32'hffffffff, 4'hf, q);
            bus(1'b0, ads[k], 32'h0, 4'hf, q);
            check(q, 32'h0);
        end
    endtask

    task t_rmii;
        // software keeps reserved bits zero
        bus(1'b1, MC, 32'h00040000, 4'hf, q);
        check(32'(rmii), 32'h1);
        bus(1'b0, MC, 32'h0, 4'hf, q); check(q, 32'h00040000);
        // lane of bit 18 not selected, so nothing changes
        bus(1'b1, MC, 32'h0, 4'hb, q); check(32'(rmii), 32'h1);
        bus(1'b1, MC, 32'h0, 4'hf, q); check(32'(rmii), 32'h0);
    endtask

    // walk each peripheral through every state code
    // each enable change is followed by a report read
    task t_codes;
        logic [31:0] a;
        for (int i = 0; i < 9; i++) begin
            a = (i == 8) ? R1 : R0;
            pd[i] <= 1'b1;
            bus(1'b0, a, 32'h0, 4'hf, q); check(q, 32'h0);
            en[i] <= 1'b1;
            pd[i] <= 1'b0;
            bus(1'b0, a, 32'h0, 4'hf, q); check(q, 32'h5 << lsb[i]);
            repeat (DONE + 2) @(posedge clk);
            bus(1'b0, a, 32'h0, 4'hf, q);
            check(q, 32'h1 << lsb[i]);
            // field positions also
            // and
            pd[i] <= 1'b1;
            bus(1'b0, a, 32'h0, 4'hf, q);
            check(q, 32'h3 << lsb[i]);
            en[i] <= 1'b0;
            pd[i] <= 1'b0;
            bus(1'b0, a, 32'h0, 4'hf, q); check(q, 32'h0);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles > LIMIT) begin
            fails++;
            give_verdict;
        end
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        en = 9'h0;
        pd = 9'h0;
        fails = 0;
        checks = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_readonly;
        t_rmii;
        t_codes;
        give_verdict;
    end
endmodule
